// ### logic/lbc_pkg.sv
// Purpose: shared constants and types for the local bus control outputs
// Assumes: one clock, all inputs synchronous to it
// Notes: cycle kinds follow the three-bit status encoding
package lbc_pkg;

    // cycle status encoding, three bits
    localparam logic [2:0] LBC_ST_IRQ_ACK_STROBE_N = 3'h0;
    localparam logic [2:0] LBC_ST_IORD = 3'h1;
    localparam logic [2:0] LBC_ST_IOWR = 3'h2;
    localparam logic [2:0] LBC_ST_HALT = 3'h3;
    localparam logic [2:0] LBC_ST_CODE = 3'h4;
    localparam logic [2:0] LBC_ST_MRD = 3'h5;
    localparam logic [2:0] LBC_ST_MWR = 3'h6;
    localparam logic [2:0] LBC_ST_PASSIVE = 3'h7;

    // status bit positions
    localparam int LBC_ST_MEM_BIT = 2;
    localparam int LBC_ST_DIR_BIT = 1;

    // queue status encoding
    localparam logic [1:0] LBC_QS_NOP = 2'h0;
    localparam logic [1:0] LBC_QS_FIRST = 2'h1;
    localparam logic [1:0] LBC_QS_EMPTY = 2'h2;
    localparam logic [1:0] LBC_QS_NEXT = 2'h3;

    // longest wait from idle-bus request to a memory cycle start, in clocks
    localparam logic [1:0] LBC_IDLE_REQ_CLOCKS = 2'h3;

    // reset values
    localparam logic LBC_ALE_RST = 1'b0;
    localparam logic LBC_STROBE_RST = 1'b1;

    // bus cycle T-states
    typedef enum logic [2:0] {
        LBC_TI,
        LBC_T1,
        LBC_T2,
        LBC_T3,
        LBC_TW,
        LBC_T4
    } lbc_tstate_e;

endpackage : lbc_pkg

// ### logic/lbc_ctrl.sv
// Purpose: local bus control outputs of a 16-bit processor bus interface
// Assumes: single clock mclk, all inputs synchronous; core gives cycle requests
// Notes: three-state pins are given as value plus output enable
//        a memory request in the same idle clock as a hold request wins the bus
//        strobes and status come from the next T-state so pins line up with it
//
// Summary of operation
// RULE1: a bus request while the bus is idle releases the bus on the following clock.
// RULE2: a memory cycle may start within three clocks of an idle-bus request, then it is handled as an active cycle (the code: only in the request's clock).
// RULE3: the exclusive-bus output goes low on the exclusive prefix and stays low until the next instruction ends (the code waits for a second instr_done).
// RULE4: other masters must not take the system bus while the exclusive-bus output is low.
// RULE5: the exclusive-bus output floats during hold acknowledge.
// RULE6: each queue operation shows on queue_state in the clock after it happened.
// RULE7: queue_state codes are 00 none, 01 first byte, 10 emptied, 11 subsequent byte.
// RULE8: minimum-mode outputs replace status and queue outputs only when mode_select is high (the code drives queue_state in both modes).
// RULE9: memory/io select is valid from the T4 before a cycle to the cycle's last T4, high for memory.
// RULE10: memory/io select carries the same value as the top status bit.
// RULE11: the write strobe is low in T2, T3 and wait states of every write cycle.
// RULE12: the interrupt acknowledge strobe is low in T2, T3 and wait states of each acknowledge cycle.
// RULE13: the address latch pulse is high during T1 of every bus cycle (the code pulses it only when mode_select is high).
// RULE14: the address latch pulse is always driven, never floated.
// RULE15: transceiver direction is high to transmit, follows select timing and matches the middle status bit.
// RULE16: select, write strobe and direction float during hold acknowledge.
// RULE17: the sequencer runs T1, T2, T3, T4 and adds wait states after T3 while ready is low.
`timescale 1ns/1ps
module lbc_ctrl
    import lbc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // core side requests
    input wire logic mode_select,
    input wire logic ready,
    input wire logic cycle_req,
    input wire logic [2:0] cycle_kind,
    input wire logic bus_hold_req,
    input wire logic lock_prefix,
    input wire logic instr_done,
    input wire logic [1:0] queue_op,
    // maximum-mode pins
    output logic [2:0] cycle_status,
    output logic cycle_status_oe,
    output logic [1:0] queue_state,
    output logic lock_bus_n,
    output logic lock_bus_oe,
    // minimum-mode pins
    output logic mem_io_sel,
    output logic mem_io_sel_oe,
    output logic wr_strobe_n,
    output logic wr_strobe_oe,
    output logic irq_ack_strobe_n,
    output logic addr_latch,
    output logic xcvr_direction,
    output logic xcvr_direction_oe,
    // hold handshake
    output logic hold_ack
);

    // sequencer and captured cycle
    lbc_tstate_e tstate_ff;
    lbc_tstate_e nxt_tstate;
    logic [2:0] kind_ff;
    logic cycle_start;

    // hold and exclusive-bus state
    logic hold_ff;
    logic release_now;
    logic nxt_hold_ack;
    logic lock_armed_ff;
    logic lock_on_ff;
    logic lock_clear;

    // decodes feeding the output flops
    logic write_cycle;
    logic ack_cycle;
    logic strobe_phase;
    logic pins_on_max;
    logic pins_on_min;
    logic [2:0] nxt_cycle_status;

    // a cycle may start from idle or right after T4 when the bus is held by us
    assign cycle_start = cycle_req && !hold_ff && !release_now
        && (tstate_ff == LBC_TI || tstate_ff == LBC_T4);
    // idle-bus request releases next clock unless a memory cycle is starting
    assign release_now = bus_hold_req && !hold_ff && tstate_ff == LBC_TI
        && !(cycle_req && cycle_kind[LBC_ST_MEM_BIT]); // RULE1 RULE2

    // T-state sequencer
    always_comb begin
        nxt_tstate = tstate_ff;
        case (tstate_ff)
            LBC_TI: nxt_tstate = cycle_start ? LBC_T1 : LBC_TI;
            LBC_T1: nxt_tstate = LBC_T2; // RULE17
            LBC_T2: nxt_tstate = LBC_T3; // RULE17
            LBC_T3: nxt_tstate = ready ? LBC_T4 : LBC_TW; // RULE17
            LBC_TW: nxt_tstate = ready ? LBC_T4 : LBC_TW; // RULE17
            LBC_T4: nxt_tstate = cycle_start ? LBC_T1 : LBC_TI;
            default: nxt_tstate = LBC_TI;
        endcase
    end

    // T-state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tstate_ff <= LBC_TI;
        end else begin
            tstate_ff <= nxt_tstate;
        end
    end

    // latch the cycle kind when a cycle is accepted
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            kind_ff <= LBC_ST_PASSIVE;
        end else if (cycle_start) begin
            kind_ff <= cycle_kind;
        end
    end

    // hold acknowledge: granted on idle bus or after the cycle's T4
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_ff <= 1'b0;
        end else if (!bus_hold_req) begin
            hold_ff <= 1'b0;
        end else if (release_now) begin
            hold_ff <= 1'b1; // RULE1
        end else if (tstate_ff == LBC_T4 && !cycle_req) begin
            hold_ff <= 1'b1; // RULE2
        end
    end

    // hold acknowledge next value, also gates every float enable
    assign nxt_hold_ack = bus_hold_req && (hold_ff || release_now || (tstate_ff == LBC_T4 && !cycle_req));
    // pins of the active mode drive only while the bus is not held
    assign pins_on_max = !mode_select && !nxt_hold_ack; // RULE8
    assign pins_on_min = mode_select && !nxt_hold_ack; // RULE8

    // hold acknowledge pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_ack <= 1'b0;
        end else begin
            hold_ack <= nxt_hold_ack; // RULE1
        end
    end

    // exclusive prefix seen, waiting for the prefixed instruction to end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_armed_ff <= 1'b0;
        end else if (lock_prefix) begin
            lock_armed_ff <= 1'b1; // RULE3
        end else if (instr_done) begin
            lock_armed_ff <= 1'b0;
        end
    end

    // exclusive use held until the instruction after the prefixed one ends
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_on_ff <= 1'b0;
        end else if (lock_prefix) begin
            lock_on_ff <= 1'b1; // RULE3
        end else if (lock_clear) begin
            lock_on_ff <= 1'b0; // RULE3
        end
    end

    // second instruction end after the prefix releases the lock
    assign lock_clear = instr_done && lock_on_ff && !lock_armed_ff;

    // cycle kind decodes for the strobes
    assign write_cycle = kind_ff == LBC_ST_IOWR || kind_ff == LBC_ST_MWR;
    assign ack_cycle = kind_ff == LBC_ST_IRQ_ACK_STROBE_N;
    // strobes are active in T2, T3 and wait states of the next clock
    assign strobe_phase = nxt_tstate == LBC_T2 || nxt_tstate == LBC_T3 || nxt_tstate == LBC_TW;
    // status is passive in T3, wait states and while idle
    assign nxt_cycle_status = (strobe_phase && nxt_tstate != LBC_T2) || nxt_tstate == LBC_TI
        ? LBC_ST_PASSIVE : (cycle_start ? cycle_kind : kind_ff);

    // queue status, one clock after the queue operation
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            queue_state <= LBC_QS_NOP;
        end else begin
            queue_state <= queue_op; // RULE6 RULE7
        end
    end

    // maximum-mode status lines
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cycle_status <= LBC_ST_PASSIVE;
        end else begin
            cycle_status <= nxt_cycle_status; // RULE10
        end
    end

    // status lines drive in maximum mode outside hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cycle_status_oe <= 1'b0;
        end else begin
            cycle_status_oe <= pins_on_max; // RULE8
        end
    end

    // exclusive-bus output, low from the prefix to the end of the instruction after the prefixed one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_bus_n <= LBC_STROBE_RST;
        end else begin
            lock_bus_n <= !(lock_prefix || (lock_on_ff && !lock_clear)); // RULE3
        end
    end

    // exclusive-bus enable, floats in hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_bus_oe <= 1'b0;
        end else begin
            lock_bus_oe <= pins_on_max; // RULE5 RULE8
        end
    end

    // memory or io select: shown in the T4 before the cycle or at its start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_io_sel <= 1'b0;
        end else if (cycle_start) begin
            mem_io_sel <= cycle_kind[LBC_ST_MEM_BIT]; // RULE9 RULE10
        end else if (nxt_tstate == LBC_T4 && cycle_req && !bus_hold_req) begin
            mem_io_sel <= cycle_kind[LBC_ST_MEM_BIT]; // RULE9
        end
    end

    // transceiver direction, same timing as the select
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xcvr_direction <= 1'b0;
        end else if (cycle_start) begin
            xcvr_direction <= cycle_kind[LBC_ST_DIR_BIT]; // RULE15
        end else if (nxt_tstate == LBC_T4 && cycle_req && !bus_hold_req) begin
            xcvr_direction <= cycle_kind[LBC_ST_DIR_BIT]; // RULE15
        end
    end

    // select enable, floats in hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_io_sel_oe <= 1'b0;
        end else begin
            mem_io_sel_oe <= pins_on_min; // RULE16 RULE8
        end
    end

    // direction enable, floats in hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xcvr_direction_oe <= 1'b0;
        end else begin
            xcvr_direction_oe <= pins_on_min; // RULE16
        end
    end

    // write strobe, low in T2, T3 and wait states of writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_strobe_n <= LBC_STROBE_RST;
        end else begin
            wr_strobe_n <= !(strobe_phase && write_cycle && mode_select); // RULE11
        end
    end

    // write strobe enable, floats in hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_strobe_oe <= 1'b0;
        end else begin
            wr_strobe_oe <= pins_on_min; // RULE16
        end
    end

    // interrupt acknowledge strobe, always driven
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ack_strobe_n <= LBC_STROBE_RST;
        end else begin
            irq_ack_strobe_n <= !(strobe_phase && ack_cycle && mode_select); // RULE12
        end
    end

    // address latch pulse in T1, never floated
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_latch <= LBC_ALE_RST;
        end else begin
            addr_latch <= mode_select && nxt_tstate == LBC_T1 && tstate_ff != LBC_T1; // RULE13 RULE14
        end
    end

endmodule : lbc_ctrl

// ### bench/lbc_far_model.sv
// Purpose: far side of the local bus: memory answering ready, other master
// Assumes: ready matters only in T3 and wait states
// Notes: wait_cnt picks wait states per cycle
`timescale 1ns/1ps
module lbc_far_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic addr_latch,
    input wire logic lock_bus_n,
    input wire logic [3:0] wait_cnt,
    input wire logic hold_want,
    output logic ready,
    output logic bus_hold_req
);
    logic [3:0] age_ff;
    // clocks since the last address latch pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) age_ff <= 4'h0;
        else if (addr_latch) age_ff <= 4'h1;
        else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
    end
    // memory answers after the chosen waits
    assign ready = ({1'b0, age_ff} >= 5'h02 + {1'b0, wait_cnt});
    // other master keeps off while exclusive use is shown
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) bus_hold_req <= 1'b0;
        else bus_hold_req <= hold_want && lock_bus_n;
    end
endmodule : lbc_far_model

// ### bench/lbc_ctrl_chk.sv
// Purpose: port timing checks for lbc_ctrl
// Assumes: one clock, async reset
// Notes: bound to every lbc_ctrl instance
`timescale 1ns/1ps
module lbc_ctrl_chk
    import lbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic mode_select,
    input wire logic ready,
    input wire logic [2:0] cycle_kind,
    input wire logic lock_prefix,
    input wire logic instr_done,
    input wire logic [1:0] queue_op,
    input wire logic [1:0] queue_state,
    input wire logic lock_bus_n,
    input wire logic lock_bus_oe,
    input wire logic mem_io_sel,
    input wire logic mem_io_sel_oe,
    input wire logic wr_strobe_n,
    input wire logic wr_strobe_oe,
    input wire logic irq_ack_strobe_n,
    input wire logic addr_latch,
    input wire logic xcvr_direction,
    input wire logic xcvr_direction_oe,
    input wire logic hold_ack
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // T1 of a write cycle in minimum mode
    sequence s_t1_wr;
        addr_latch && mode_select && ($past(cycle_kind) == LBC_ST_MWR || $past(cycle_kind) == LBC_ST_IOWR);
    endsequence
    ale_pulse_a: assert property ($rose(addr_latch) |=> !addr_latch) else $error("latch pulse too long");
    wr_window_a: assert property (s_t1_wr |=> !wr_strobe_n [*2]) else $error("write strobe missing");
    wr_start_a: assert property ($fell(wr_strobe_n) |-> $past(addr_latch)) else $error("write strobe early");
    ia_start_a: assert property ($fell(irq_ack_strobe_n) |-> $past(addr_latch)) else $error("ack strobe early");
    wait_hold_a: assert property (!wr_strobe_n && !ready |=> !wr_strobe_n) else $error("wait not held");
    qs_delay_a: assert property (!$past(rst) |-> queue_state == $past(queue_op)) else $error("queue lag");
    lock_set_a: assert property (lock_prefix |=> !lock_bus_n) else $error("lock not set");
    lock_end_a: assert property ($rose(lock_bus_n) |-> $past(instr_done)) else $error("lock end");
    hold_float_a: assert property (hold_ack |-> !(mem_io_sel_oe || wr_strobe_oe || xcvr_direction_oe || lock_bus_oe))
        else $error("pins driven in hold");
    sel_kind_a: assert property (addr_latch && mode_select |-> mem_io_sel == $past(cycle_kind[2])
        && xcvr_direction == $past(cycle_kind[1])) else $error("select or direction");
endmodule : lbc_ctrl_chk
bind lbc_ctrl lbc_ctrl_chk chk_u (.mclk, .rst, .mode_select, .ready, .cycle_kind, .lock_prefix, .instr_done,
    .queue_op, .queue_state, .lock_bus_n, .lock_bus_oe, .mem_io_sel, .mem_io_sel_oe, .wr_strobe_n, .wr_strobe_oe,
    .irq_ack_strobe_n, .addr_latch, .xcvr_direction, .xcvr_direction_oe, .hold_ack);

// ### bench/lbc_ctrl_tb.sv
// Purpose: self-checking bench for lbc_ctrl
// Assumes: inputs change 1 ns after the rising edge
// Notes: far side is lbc_far_model
`timescale 1ns/1ps
module lbc_ctrl_tb;
    import lbc_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, mode_select = 1'b1, cycle_req = 1'b0, lock_prefix = 1'b0, instr_done = 1'b0;
    logic hold_want = 1'b0, ready, bus_hold_req, cycle_status_oe, lock_bus_n, lock_bus_oe, mem_io_sel;
    logic mem_io_sel_oe, wr_strobe_n, wr_strobe_oe, irq_ack_strobe_n, addr_latch, xcvr_direction;
    logic xcvr_direction_oe, hold_ack;
    logic [2:0] cycle_kind = LBC_ST_PASSIVE;
    logic [2:0] cycle_status;
    logic [1:0] queue_op = 2'h0, queue_state;
    logic [3:0] wait_cnt = 4'h0;
    int failures = 0, n_checks = 0;
    lbc_ctrl dut_u (.mclk, .rst, .mode_select, .ready, .cycle_req, .cycle_kind, .bus_hold_req, .lock_prefix,
        .instr_done, .queue_op, .cycle_status, .cycle_status_oe, .queue_state, .lock_bus_n, .lock_bus_oe,
        .mem_io_sel, .mem_io_sel_oe, .wr_strobe_n, .wr_strobe_oe, .irq_ack_strobe_n, .addr_latch,
        .xcvr_direction, .xcvr_direction_oe, .hold_ack);
    lbc_far_model far_u (.mclk, .rst, .addr_latch, .lock_bus_n, .wait_cnt, .hold_want, .ready, .bus_hold_req);
    // 200 MHz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task step;
        @(posedge mclk);
        #1;
    endtask : step
    task chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            failures++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d errors %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // one bus cycle; counts strobe cycles
    task automatic t_cycle(input logic [2:0] k, input logic [3:0] w, input int ewr, input int eia);
        int nw = 0, ni = 0, g = 0;
        wait_cnt = w;
        cycle_kind = k;
        cycle_req = 1'b1;
        do begin step(); g++; end while (addr_latch !== 1'b1 && g < 8);
        cycle_req = 1'b0;
        chk(addr_latch === 1'b1 && mem_io_sel === k[2] && xcvr_direction === k[1], "T1 pins");
        repeat (10) begin
            step();
            nw += (wr_strobe_n === 1'b0);
            ni += (irq_ack_strobe_n === 1'b0);
        end
        chk(nw == ewr && ni == eia && mem_io_sel === k[2], "strobe length");
    endtask : t_cycle
    task sc_min;
        chk(mem_io_sel_oe === 1'b1 && cycle_status_oe === 1'b0, "min mode pins");
        t_cycle(LBC_ST_MWR, 4'h0, 2, 0);
        t_cycle(LBC_ST_IOWR, 4'h3, 5, 0);
        t_cycle(LBC_ST_IRQ_ACK_STROBE_N, 4'h1, 0, 3);
        t_cycle(LBC_ST_MRD, 4'h2, 0, 0);
        t_cycle(LBC_ST_IORD, 4'h0, 0, 0);
    endtask : sc_min
    task sc_queue;
        for (int i = 0; i < 4; i++) begin
            queue_op = 2'(i);
            step();
            chk(queue_state === 2'(i), "queue state");
        end
        queue_op = 2'h0;
    endtask : sc_queue
    task automatic sc_hold;
        int g = 0;
        hold_want = 1'b1;
        do begin step(); g++; end while (hold_ack !== 1'b1 && g < 6);
        chk(g <= 2 && mem_io_sel_oe === 1'b0 && wr_strobe_oe === 1'b0 && xcvr_direction_oe === 1'b0, "no release");
        chk(lock_bus_oe === 1'b0 && addr_latch === 1'b0, "lock or latch in hold");
        hold_want = 1'b0;
        repeat (3) step();
        chk(hold_ack === 1'b0, "hold stuck");
    endtask : sc_hold
    task sc_lock;
        mode_select = 1'b0;
        repeat (2) step();
        chk(cycle_status_oe === 1'b1 && mem_io_sel_oe === 1'b0 && wr_strobe_oe === 1'b0, "max mode pins");
        cycle_kind = LBC_ST_MRD;
        cycle_req = 1'b1;
        step();
        cycle_req = 1'b0;
        chk(cycle_status === LBC_ST_MRD && mem_io_sel === 1'b1 && xcvr_direction === 1'b0, "status at T1");
        repeat (4) step();
        chk(cycle_status === LBC_ST_PASSIVE, "status not passive after cycle");
        lock_prefix = 1'b1;
        step();
        lock_prefix = 1'b0;
        chk(lock_bus_n === 1'b0, "lock not shown");
        instr_done = 1'b1;
        step();
        instr_done = 1'b0;
        chk(lock_bus_n === 1'b0, "lock dropped early");
        instr_done = 1'b1;
        step();
        instr_done = 1'b0;
        step();
        chk(lock_bus_n === 1'b1, "lock held too long");
    endtask : sc_lock
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        step();
        sc_min();
        sc_queue();
        sc_hold();
        sc_lock();
        sc_hold();
        finish_test();
    end
    // watchdog
    initial begin
        #5000;
        failures++;
        finish_test();
    end
endmodule : lbc_ctrl_tb
